// file: src/dmem_pkg.sv
// package: data memory map constants, register offsets and field positions
package dmem_pkg;
  localparam logic [7:0] ADDR_INDIRECT_PORT_ZERO  = 8'h00;
  localparam logic [7:0] ADDR_POINTER_ZERO        = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_PORT_ONE   = 8'h02;
  localparam logic [7:0] ADDR_POINTER_ONE_LOW     = 8'h03;
  localparam logic [7:0] ADDR_POINTER_ONE_SECTOR  = 8'h04;
  localparam logic [7:0] ADDR_ACCUMULATOR         = 8'h05;
  localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_POINTER_LOW   = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH_LATCH    = 8'h08;
  localparam logic [7:0] ADDR_TABLE_POINTER_HIGH  = 8'h09;
  localparam logic [7:0] ADDR_STATUS_FLAGS        = 8'h0a;
  localparam logic [7:0] ADDR_INDIRECT_PORT_TWO   = 8'h0c;
  localparam logic [7:0] ADDR_POINTER_TWO_LOW     = 8'h0d;
  localparam logic [7:0] ADDR_POINTER_TWO_SECTOR  = 8'h0e;
  localparam logic [7:0] ADDR_NV_CONTROL          = 8'h40;
  localparam logic [7:0] SFR_LIMIT                = 8'h80;
  localparam logic [7:0] RESET_BYTE               = 8'h00;
  localparam logic [7:0] UNUSED_READ              = 8'h00;
  // status flag bits: bit 4 pdf, bit 5 to are hardware owned
  localparam logic [7:0] STATUS_SW_MASK           = 8'hcf;
  localparam int         STATUS_PDF_BIT           = 4;
  localparam int         STATUS_TO_BIT            = 5;
  localparam int         SECTOR_COUNT             = 2;
  localparam int         TABLE_CYCLES             = 2;
endpackage

// file: src/sync_two_ff.sv
// module: two flip-flop level synchroniser for pin inputs
`timescale 1ns/100ps
module sync_two_ff (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;  // first stage, read only by the second
  logic meta_d;
  logic sync_d;

  // next values: plain shift
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // register the two stages
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule

// file: src/gp_ram.sv
// module: general purpose ram, flip-flop storage with bit write mask
`timescale 1ns/100ps
module gp_ram #(
  parameter int DEPTH = 256
) (
  input  wire logic                     clk_in,
  input  wire logic [$clog2(DEPTH)-1:0] idx_in,
  input  wire logic                     we_in,
  input  wire logic [7:0]               wdata_in,
  input  wire logic [7:0]               wmask_in,
  output logic      [7:0]               rdata_out
);
  logic [7:0] mem_q [DEPTH];  // storage cells, no reset (volatile)
  logic [7:0] cell_d;         // merged byte for the addressed cell

  // merge only the masked bits so bit operations leave the others alone
  always_comb begin
    cell_d    = (mem_q[idx_in] & ~wmask_in) | (wdata_in & wmask_in);
    rdata_out = mem_q[idx_in];
  end

  // write the addressed cell
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[idx_in] <= cell_d;
    end
  end
endmodule

// file: src/sectored_data_memory_decoder.sv
// module: sectored data memory address decoder with pointers and table latch
// Function
// - table reads take exactly two cycles
// - table high latch is software readable, writable
// - addresses 00H-7FH decode special registers, sector 0
// - sector 1 address 40H is nonvolatile control
// - ram at 80H-FFH in both sectors
// - unused special locations read 00H
// - ports one, two use sector and low pointers
// - no bank register; sector from pointers, address
// - extended addresses carry nine valid bits
// - direct access reaches all sectors via extended
// - protected registers ignore software writes
// - bit operations change only selected bit
// - lowest data address is 00H
// - serial programming uses shared data, external clock
// - indirect ports act on pointer; direct reads zero
// - port zero reaches sector 0 only
`timescale 1ns/100ps
module sectored_data_memory_decoder
  import dmem_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [8:0] addr_in,          // nine bit operand address, bit 8 sector
  input  wire logic       ext_in,           // extended form: bit 8 is valid
  input  wire logic       rd_in,            // read strobe
  input  wire logic       wr_in,            // write strobe
  input  wire logic [7:0] wdata_in,         // write data
  input  wire logic [7:0] wmask_in,         // bit mask, ff for whole byte
  input  wire logic       tbl_start_in,     // begin table read
  input  wire logic [8:0] tbl_dest_in,      // destination of low table byte
  input  wire logic [15:0] tbl_word_in,     // program memory word
  input  wire logic       status_hw_we_in,  // hardware status flag update
  input  wire logic [1:0] status_hw_in,     // {to, pdf} from power logic
  input  wire logic       prog_data_in,     // programming_serial_data pin in
  input  wire logic       prog_clk_in,      // programming_serial_clock pin
  input  wire logic       prog_data_drive_in, // programmer requests device drive
  input  wire logic       prog_bit_in,      // bit to send back when driving
  output logic [7:0]      rdata_out,        // registered read data
  output logic            rvalid_out,       // read data valid pulse
  output logic            tbl_busy_out,     // table read in progress
  output logic            tbl_done_out,     // table read complete pulse
  output logic [7:0]      nv_control_out,   // nonvolatile control register
  output logic [7:0]      table_ptr_low_out,
  output logic [7:0]      table_ptr_high_out,
  output logic            prog_data_out,    // serial data out
  output logic            prog_data_oe_out, // high while device drives pin
  output logic            prog_data_s_out,  // synchronised serial data
  output logic            prog_clk_s_out    // synchronised serial clock
);
  // ---- special function registers ----
  logic [7:0] pointer_zero_q, pointer_zero_d;
  logic [7:0] pointer_one_low_q, pointer_one_low_d;
  logic [7:0] pointer_one_sector_q, pointer_one_sector_d;
  logic [7:0] pointer_two_low_q, pointer_two_low_d;
  logic [7:0] pointer_two_sector_q, pointer_two_sector_d;
  logic [7:0] accumulator_q, accumulator_d;
  logic [7:0] program_counter_low_q, program_counter_low_d;
  logic [7:0] table_pointer_low_q, table_pointer_low_d;
  logic [7:0] table_high_latch_q, table_high_latch_d;
  logic [7:0] table_pointer_high_q, table_pointer_high_d;
  logic [7:0] status_flags_q, status_flags_d;
  logic [7:0] nv_control_q, nv_control_d;
  logic [7:0] rdata_d;
  logic       rvalid_d;

  // table read sequencer
  typedef enum {TBL_IDLE, TBL_FETCH, TBL_STORE} tbl_state_e;
  tbl_state_e tbl_state_q, tbl_state_d;
  logic [8:0] tbl_dest_q, tbl_dest_d;       // latched destination
  logic [7:0] tbl_low_q, tbl_low_d;         // latched low table byte
  logic       tbl_done_d;

  // resolved access
  logic       eff_sector;                   // resolved sector bit
  logic [7:0] eff_addr;                     // resolved in-sector address
  logic       eff_valid;                    // pointer path allowed
  logic       acc_we;                       // effective write this cycle
  logic [7:0] acc_wdata;
  logic [7:0] acc_wmask;
  localparam int RAM_IDX_W = $clog2(RAM_DEPTH);  // ram index width, sector bit on top
  logic       ram_we;
  logic [RAM_IDX_W-1:0] ram_idx;
  logic [7:0] ram_rdata;
  logic [7:0] sfr_rdata;
  logic [7:0] merged;                       // masked write into a register

  // ---- programming pins: synchronise both before use ----
  sync_two_ff u_sync_data (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (prog_data_in),
    .sync_out (prog_data_s_out)
  );
  sync_two_ff u_sync_clk (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (prog_clk_in),
    .sync_out (prog_clk_s_out)
  );

  // ---- storage for general purpose memory ----
  gp_ram #(.DEPTH(RAM_DEPTH)) u_ram (
    .clk_in    (clk_in),
    .idx_in    (ram_idx),
    .we_in     (ram_we),
    .wdata_in  (acc_wdata),
    .wmask_in  (acc_wmask),
    .rdata_out (ram_rdata)
  );

  // address resolution: direct, extended, or through a pointer
  always_comb begin
    eff_valid  = 1'b1;
    acc_wdata  = wdata_in;
    acc_wmask  = wmask_in;
    acc_we     = wr_in;
    // no bank register: sector comes from the address or a pointer
    eff_sector = ext_in ? addr_in[8] : 1'b0;
    eff_addr   = addr_in[7:0];
    if (tbl_state_q == TBL_STORE) begin
      // table store owns the memory port for its second cycle
      eff_sector = tbl_dest_q[8];
      eff_addr   = tbl_dest_q[7:0];
      acc_wdata  = tbl_low_q;
      acc_wmask  = 8'hff;
      acc_we     = 1'b1;
    end else if (eff_sector == 1'b0) begin
      case (eff_addr)
        ADDR_INDIRECT_PORT_ZERO: begin
          eff_addr   = pointer_zero_q;
        end
        ADDR_INDIRECT_PORT_ONE: begin
          eff_sector = pointer_one_sector_q[0];
          eff_addr   = pointer_one_low_q;
          eff_valid  = (pointer_one_sector_q < 8'(SECTOR_COUNT));
        end
        ADDR_INDIRECT_PORT_TWO: begin
          eff_sector = pointer_two_sector_q[0];
          eff_addr   = pointer_two_low_q;
          eff_valid  = (pointer_two_sector_q < 8'(SECTOR_COUNT));
        end
        default: begin
          eff_valid = 1'b1;
        end
      endcase
      // a pointer naming a port again: direct port access reads zero, writes nothing
      if (eff_sector == 1'b0 && (eff_addr == ADDR_INDIRECT_PORT_ZERO ||
          eff_addr == ADDR_INDIRECT_PORT_ONE || eff_addr == ADDR_INDIRECT_PORT_TWO)) begin
        eff_valid = 1'b0;
      end
    end
    ram_we  = acc_we && eff_valid && eff_addr[7];
    ram_idx = RAM_IDX_W'({eff_sector, eff_addr[6:0]});
  end

  // special register read mux: sector 0 low half, sector 1 only 40H
  always_comb begin
    sfr_rdata = UNUSED_READ;
    if (!eff_sector) begin
      case (eff_addr)
        ADDR_POINTER_ZERO:        sfr_rdata = pointer_zero_q;
        ADDR_POINTER_ONE_LOW:     sfr_rdata = pointer_one_low_q;
        ADDR_POINTER_ONE_SECTOR:  sfr_rdata = pointer_one_sector_q;
        ADDR_ACCUMULATOR:         sfr_rdata = accumulator_q;
        ADDR_PROGRAM_COUNTER_LOW: sfr_rdata = program_counter_low_q;
        ADDR_TABLE_POINTER_LOW:   sfr_rdata = table_pointer_low_q;
        ADDR_TABLE_HIGH_LATCH:    sfr_rdata = table_high_latch_q;
        ADDR_TABLE_POINTER_HIGH:  sfr_rdata = table_pointer_high_q;
        ADDR_STATUS_FLAGS:        sfr_rdata = status_flags_q;
        ADDR_POINTER_TWO_LOW:     sfr_rdata = pointer_two_low_q;
        ADDR_POINTER_TWO_SECTOR:  sfr_rdata = pointer_two_sector_q;
        default:                  sfr_rdata = UNUSED_READ;
      endcase
    end else if (eff_addr == ADDR_NV_CONTROL) begin
      sfr_rdata = nv_control_q;
    end
  end

  // register writes and read data capture
  always_comb begin
    pointer_zero_d        = pointer_zero_q;
    pointer_one_low_d     = pointer_one_low_q;
    pointer_one_sector_d  = pointer_one_sector_q;
    pointer_two_low_d     = pointer_two_low_q;
    pointer_two_sector_d  = pointer_two_sector_q;
    accumulator_d         = accumulator_q;
    program_counter_low_d = program_counter_low_q;
    table_pointer_low_d   = table_pointer_low_q;
    table_high_latch_d    = table_high_latch_q;
    table_pointer_high_d  = table_pointer_high_q;
    status_flags_d        = status_flags_q;
    nv_control_d          = nv_control_q;
    merged                = (sfr_rdata & ~acc_wmask) | (acc_wdata & acc_wmask);
    if (acc_we && eff_valid && !eff_addr[7]) begin
      if (!eff_sector) begin
        case (eff_addr)
          ADDR_POINTER_ZERO:        pointer_zero_d        = merged;
          ADDR_POINTER_ONE_LOW:     pointer_one_low_d     = merged;
          ADDR_POINTER_ONE_SECTOR:  pointer_one_sector_d  = merged;
          ADDR_ACCUMULATOR:         accumulator_d         = merged;
          ADDR_PROGRAM_COUNTER_LOW: program_counter_low_d = merged;
          ADDR_TABLE_POINTER_LOW:   table_pointer_low_d   = merged;
          ADDR_TABLE_HIGH_LATCH:    table_high_latch_d    = merged;
          ADDR_TABLE_POINTER_HIGH:  table_pointer_high_d  = merged;
          // protected flags keep their value on software writes
          ADDR_STATUS_FLAGS: status_flags_d = (merged & STATUS_SW_MASK) |
                                              (status_flags_q & ~STATUS_SW_MASK);
          ADDR_POINTER_TWO_LOW:     pointer_two_low_d     = merged;
          ADDR_POINTER_TWO_SECTOR:  pointer_two_sector_d  = merged;
          default:                  pointer_zero_d        = pointer_zero_q;
        endcase
      end else if (eff_addr == ADDR_NV_CONTROL) begin
        nv_control_d = merged;
      end
    end
    // hardware owned flags: only the power logic moves them
    if (status_hw_we_in) begin
      status_flags_d[STATUS_PDF_BIT] = status_hw_in[0];
      status_flags_d[STATUS_TO_BIT]  = status_hw_in[1];
    end
    // the table high byte lands in the latch at the end of the fetch cycle
    if (tbl_state_q == TBL_FETCH) begin
      table_high_latch_d = tbl_word_in[15:8];
    end
    rvalid_d = rd_in && (tbl_state_q != TBL_STORE);
    if (!eff_valid) begin
      rdata_d = UNUSED_READ;
    end else if (eff_addr[7]) begin
      rdata_d = ram_rdata;
    end else begin
      rdata_d = sfr_rdata;
    end
  end

  // table read: start, fetch word, store low byte; two cycles of work
  always_comb begin
    tbl_state_d = tbl_state_q;
    tbl_dest_d  = tbl_dest_q;
    tbl_low_d   = tbl_low_q;
    tbl_done_d  = 1'b0;
    case (tbl_state_q)
      TBL_IDLE: begin
        if (tbl_start_in) begin
          tbl_dest_d  = tbl_dest_in;
          tbl_state_d = TBL_FETCH;
        end
      end
      TBL_FETCH: begin
        tbl_low_d   = tbl_word_in[7:0];
        tbl_state_d = TBL_STORE;
      end
      TBL_STORE: begin
        tbl_done_d  = 1'b1;
        tbl_state_d = TBL_IDLE;
      end
      default: begin
        tbl_state_d = TBL_IDLE;
      end
    endcase
  end

  // register all state; outputs come straight from flip-flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pointer_zero_q        <= RESET_BYTE;
      pointer_one_low_q     <= RESET_BYTE;
      pointer_one_sector_q  <= RESET_BYTE;
      pointer_two_low_q     <= RESET_BYTE;
      pointer_two_sector_q  <= RESET_BYTE;
      accumulator_q         <= RESET_BYTE;
      program_counter_low_q <= RESET_BYTE;
      table_pointer_low_q   <= RESET_BYTE;
      table_high_latch_q    <= RESET_BYTE;
      table_pointer_high_q  <= RESET_BYTE;
      status_flags_q        <= RESET_BYTE;
      nv_control_q          <= RESET_BYTE;
      tbl_state_q           <= TBL_IDLE;
      tbl_dest_q            <= 9'h000;
      tbl_low_q             <= RESET_BYTE;
      rdata_out             <= RESET_BYTE;
      rvalid_out            <= 1'b0;
      tbl_busy_out          <= 1'b0;
      tbl_done_out          <= 1'b0;
      nv_control_out        <= RESET_BYTE;
      table_ptr_low_out     <= RESET_BYTE;
      table_ptr_high_out    <= RESET_BYTE;
      prog_data_out         <= 1'b0;
      prog_data_oe_out      <= 1'b0;
    end else begin
      pointer_zero_q        <= pointer_zero_d;
      pointer_one_low_q     <= pointer_one_low_d;
      pointer_one_sector_q  <= pointer_one_sector_d;
      pointer_two_low_q     <= pointer_two_low_d;
      pointer_two_sector_q  <= pointer_two_sector_d;
      accumulator_q         <= accumulator_d;
      program_counter_low_q <= program_counter_low_d;
      table_pointer_low_q   <= table_pointer_low_d;
      table_high_latch_q    <= table_high_latch_d;
      table_pointer_high_q  <= table_pointer_high_d;
      status_flags_q        <= status_flags_d;
      nv_control_q          <= nv_control_d;
      tbl_state_q           <= tbl_state_d;
      tbl_dest_q            <= tbl_dest_d;
      tbl_low_q             <= tbl_low_d;
      rdata_out             <= rdata_d;
      rvalid_out            <= rvalid_d;
      tbl_busy_out          <= (tbl_state_d != TBL_IDLE);
      tbl_done_out          <= tbl_done_d;
      nv_control_out        <= nv_control_d;
      table_ptr_low_out     <= table_pointer_low_d;
      table_ptr_high_out    <= table_pointer_high_d;
      // one shared line: drive only when the programmer hands it over
      prog_data_out         <= prog_bit_in;
      prog_data_oe_out      <= prog_data_drive_in;
    end
  end
endmodule

// file: bench/sdmd_props.sv
// checker: port-level timing and decode properties of the sectored data memory decoder
`timescale 1ns/100ps
module sdmd_props
  import dmem_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [8:0] addr_in,
  input wire logic       ext_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] wmask_in,
  input wire logic       tbl_start_in,
  input wire logic       prog_clk_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rvalid_out,
  input wire logic       tbl_busy_out,
  input wire logic       tbl_done_out,
  input wire logic [7:0] nv_control_out,
  input wire logic [7:0] table_ptr_low_out,
  input wire logic       prog_clk_s_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [1:0] up_q;  // cycles since reset, saturating
  logic [1:0] up_d;
  logic       s0;    // access lands in sector 0
  assign s0 = !ext_in || !addr_in[8];
  // count settles so the synchroniser check skips stale reset state
  always_comb begin
    up_d = (up_q == 2'd3) ? up_q : up_q + 2'd1;
  end
  always_ff @(posedge clk_in) begin
    up_q <= rst_in ? 2'd0 : up_d;
  end
  a_read_answer: assert property (rd_in && !tbl_busy_out |=> rvalid_out)
    else $error("read not answered next cycle");
  a_no_spurious: assert property (!rd_in |=> !rvalid_out)
    else $error("read valid without a read");
  a_table_done: assert property (tbl_start_in && !tbl_busy_out |-> ##3 tbl_done_out)
    else $error("table read did not finish in two cycles");
  a_table_busy: assert property (tbl_start_in && !tbl_busy_out |=> tbl_busy_out[*2] ##1 !tbl_busy_out)
    else $error("table busy window wrong");
  a_unused_zero: assert property (rd_in && !tbl_busy_out && s0 && addr_in[7:0] == 8'h0b
    |=> rdata_out == UNUSED_READ)
    else $error("unused location read nonzero");
  a_sector_gap: assert property (rd_in && !tbl_busy_out && !s0 && addr_in[7:0] < SFR_LIMIT
    && addr_in[7:0] != ADDR_NV_CONTROL |=> rdata_out == UNUSED_READ)
    else $error("sector one special area read nonzero");
  a_nv_write: assert property (wr_in && !tbl_busy_out && !s0 && addr_in[7:0] == ADDR_NV_CONTROL
    && wmask_in == 8'hff |=> nv_control_out == $past(wdata_in))
    else $error("nonvolatile control not written");
  a_tptr_write: assert property (wr_in && !tbl_busy_out && s0 && addr_in[7:0] == ADDR_TABLE_POINTER_LOW
    && wmask_in == 8'hff |=> table_ptr_low_out == $past(wdata_in))
    else $error("table pointer low not written");
  a_prog_sync: assert property (up_q == 2'd3 |-> prog_clk_s_out == $past(prog_clk_in, 2))
    else $error("programming clock sync latency wrong");
endmodule
bind sectored_data_memory_decoder sdmd_props #(.RAM_DEPTH(RAM_DEPTH)) i_props (.clk_in, .rst_in, .addr_in,
  .ext_in, .rd_in, .wr_in, .wdata_in, .wmask_in, .tbl_start_in, .prog_clk_in, .rdata_out, .rvalid_out,
  .tbl_busy_out, .tbl_done_out, .nv_control_out, .table_ptr_low_out, .prog_clk_s_out);

// file: bench/prog_mem_model.sv
// model: program memory side answering table fetches
`timescale 1ns/100ps
module prog_mem_model (
  input  wire logic        clk_in,
  input  wire logic        tbl_start_in,
  input  wire logic [7:0]  ptr_low_in,
  input  wire logic [7:0]  ptr_high_in,
  output logic      [15:0] word_out
);
  logic [15:0] word_q = 16'h0000;  // word on the fetch bus
  // word valid only in the fetch cycle; otherwise it flips so stale data never matches
  always @(posedge clk_in) begin
    word_q <= tbl_start_in ? {ptr_high_in ^ 8'h3c, ptr_low_in} : ~word_q;
  end
  assign word_out = word_q;
endmodule

// file: bench/sectored_data_memory_decoder_tb_top.sv
// testbench: self-checking run over the sectored data memory decoder
`timescale 1ns/100ps
module sectored_data_memory_decoder_tb_top;
  import dmem_pkg::*;
  logic        clk_in;
  logic        rst_in = 1;
  logic        ext_in = 0, rd_in = 0, wr_in = 0, tbl_start_in = 0, status_hw_we_in = 0;
  logic        prog_clk_in = 0, host_bit = 0, prog_data_drive_in = 0, prog_bit_in = 0;
  logic [8:0]  addr_in = 0, tbl_dest_in = 0, a, port;
  logic [7:0]  wdata_in = 0, wmask_in = 0, d, m, mem [0:255];
  logic [1:0]  status_hw_in = 0;
  logic [15:0] tbl_word_in;
  logic [7:0]  rdata_out, nv_control_out, table_ptr_low_out, table_ptr_high_out;
  logic        rvalid_out, tbl_busy_out, tbl_done_out, prog_data_out, prog_data_oe_out;
  logic        prog_data_s_out, prog_clk_s_out, s, w;
  int          failures = 0, checks_done = 0, cyc = 0, k;
  wire         pin_w = prog_data_oe_out ? prog_data_out : host_bit;  // shared data line
  sectored_data_memory_decoder i_dut (.clk_in, .rst_in, .addr_in, .ext_in, .rd_in, .wr_in, .wdata_in,
    .wmask_in, .tbl_start_in, .tbl_dest_in, .tbl_word_in, .status_hw_we_in, .status_hw_in,
    .prog_data_in(pin_w), .prog_clk_in, .prog_data_drive_in, .prog_bit_in, .rdata_out, .rvalid_out,
    .tbl_busy_out, .tbl_done_out, .nv_control_out, .table_ptr_low_out, .table_ptr_high_out,
    .prog_data_out, .prog_data_oe_out, .prog_data_s_out, .prog_clk_s_out);
  prog_mem_model i_pmem (.clk_in, .tbl_start_in, .ptr_low_in(table_ptr_low_out),
    .ptr_high_in(table_ptr_high_out), .word_out(tbl_word_in));
  initial begin
    clk_in = 0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard: whole run needs under two thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      final_report();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bit-masked merge, as a bit set or clear should leave other bits alone
  function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] v, input logic [7:0] k);
    return (o & ~k) | (v & k);
  endfunction
  // one strobe cycle; sector-0 accesses randomly use the extended form too
  task automatic acc(input logic wr, input logic [8:0] ad, input logic [7:0] dv, input logic [7:0] mk);
    @(posedge clk_in);
    addr_in <= ad;
    ext_in <= ad[8] | 1'($urandom);
    wdata_in <= dv;
    wmask_in <= mk;
    rd_in <= !wr;
    wr_in <= wr;
    @(posedge clk_in);
    rd_in <= 0;
    wr_in <= 0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [8:0] ad, input logic [7:0] e);
    acc(0, ad, 8'h00, 8'h00);
    check({7'h0, rvalid_out}, 8'h01);
    check(rdata_out, e);
  endtask
  initial begin
    void'($urandom(49010));
    repeat (8) @(posedge clk_in);
    rst_in <= 0;
    rd(9'h003, RESET_BYTE);
    rd(9'h008, RESET_BYTE);
    // fill every ram byte of both sectors, then read all back
    for (int j = 0; j < 512; j++) begin
      a = {j[7], 1'b1, j[6:0]};
      if (j < 256) begin
        acc(1, a, 8'(j * 7), 8'hff);
        mem[j[7:0]] = 8'(j * 7);
      end else rd(a, mem[j[7:0]]);
    end
    // random byte and bit writes, one path direct and the other through a pointer port
    for (int i = 0; i < 60; i++) begin
      s = 1'($urandom);
      a = {s, 1'b1, 7'($urandom)};
      m = ($urandom % 2) ? 8'hff : 8'h01 << ($urandom % 8);
      d = 8'($urandom);
      k = $urandom % 3;
      if (k == 0 && s) k = 1;  // port zero cannot leave sector 0
      if (k == 0) acc(1, 9'h001, a[7:0], 8'hff);
      else begin
        acc(1, (k == 1) ? 9'h004 : 9'h00e, {7'h0, s}, 8'hff);
        acc(1, (k == 1) ? 9'h003 : 9'h00d, a[7:0], 8'hff);
      end
      port = (k == 0) ? 9'h000 : (k == 1) ? 9'h002 : 9'h00c;
      w = 1'($urandom);
      acc(1, w ? port : a, d, m);
      mem[{s, a[6:0]}] = merge(mem[{s, a[6:0]}], d, m);
      rd(w ? a : port, mem[{s, a[6:0]}]);
    end
    acc(1, 9'h001, 8'h02, 8'hff);
    rd(9'h000, UNUSED_READ);
    acc(1, 9'h001, 8'h90, 8'hff);
    acc(1, 9'h004, 8'h01, 8'hff);
    rd(9'h000, mem[8'h10]);
    acc(1, 9'h004, 8'h02, 8'hff);
    acc(1, 9'h003, 8'h90, 8'hff);
    rd(9'h002, UNUSED_READ);
    rd(9'h00b, UNUSED_READ);
    rd(9'h110, UNUSED_READ);
    acc(1, 9'h140, 8'ha5, 8'hff);
    check(nv_control_out, 8'ha5);
    rd(9'h140, 8'ha5);
    // flags 4 and 5 follow only the hardware load
    acc(1, 9'h00a, 8'hff, 8'hff);
    rd(9'h00a, STATUS_SW_MASK);
    @(posedge clk_in);
    status_hw_we_in <= 1;
    status_hw_in <= 2'b11;
    @(posedge clk_in);
    status_hw_we_in <= 0;
    acc(1, 9'h00a, 8'h00, 8'hff);
    rd(9'h00a, ~STATUS_SW_MASK);
    // table read: latch write and read back, then a fetch into sector 1 ram
    acc(1, 9'h008, 8'h5a, 8'hff);
    rd(9'h008, 8'h5a);
    d = 8'($urandom);
    m = 8'($urandom);
    acc(1, 9'h007, d, 8'hff);
    acc(1, 9'h009, m, 8'hff);
    check(table_ptr_high_out, m);
    @(posedge clk_in);
    tbl_start_in <= 1;
    tbl_dest_in <= 9'h185;
    @(posedge clk_in);
    tbl_start_in <= 0;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (tbl_done_out !== 1'b1 && k < 8);
    check(8'(k), 8'(TABLE_CYCLES + 1));
    mem[8'h85] = d;
    rd(9'h185, d);
    rd(9'h008, m ^ 8'h3c);
    // programming pins: clock toggles, device drives then releases the data line
    repeat (12) @(posedge clk_in) prog_clk_in <= ~prog_clk_in;
    @(posedge clk_in);
    prog_data_drive_in <= 1;
    prog_bit_in <= 1;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    check({6'h0, prog_data_oe_out, prog_data_s_out}, 8'h03);
    @(posedge clk_in);
    prog_data_drive_in <= 0;
    prog_bit_in <= 0;
    host_bit <= 0;  // host drives the opposite of the device's last bit once released
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    check({6'h0, prog_data_oe_out, prog_data_s_out}, 8'h00);
    final_report();
  end
endmodule
